// ---- rtl/ivp_pkg.sv ----
// ============================================================================
// Shared constants for the interrupt vector priority selector.
package ivp_pkg;

    // ========================================================================
    // Variants and widths.
    localparam int          IVP_ADDR_W         = 14;
    localparam int          IVP_NUM_SRC        = 8;
    localparam logic [1:0]  IVP_VAR_TWO_PORT   = 2'h0;
    localparam logic [1:0]  IVP_VAR_ONE_PORT   = 2'h1;
    localparam logic [1:0]  IVP_VAR_HOST_PORT  = 2'h2;

    // ========================================================================
    // Source index in priority order, highest first.
    localparam int          IVP_SRC_DEDICATED  = 0;
    localparam int          IVP_SRC_HOST_WR    = 1;
    localparam int          IVP_SRC_HOST_RD    = 2;
    localparam int          IVP_SRC_SP0_TX     = 3;
    localparam int          IVP_SRC_SP0_RX     = 4;
    localparam int          IVP_SRC_SHARED_TX  = 5;
    localparam int          IVP_SRC_SHARED_RX  = 6;
    localparam int          IVP_SRC_TIMER      = 7;

    // ========================================================================
    // Vector addresses; each slot spans this many instruction words.
    localparam logic [13:0] IVP_VEC_RESET      = 14'h0000;
    localparam logic [13:0] IVP_VEC_DEDICATED  = 14'h0004;
    localparam logic [13:0] IVP_VEC_0008       = 14'h0008;
    localparam logic [13:0] IVP_VEC_000C       = 14'h000C;
    localparam logic [13:0] IVP_VEC_0010       = 14'h0010;
    localparam logic [13:0] IVP_VEC_0014       = 14'h0014;
    localparam logic [13:0] IVP_VEC_0018       = 14'h0018;
    localparam logic [13:0] IVP_VEC_001C       = 14'h001C;
    localparam logic [13:0] IVP_VEC_0020       = 14'h0020;
    localparam logic [13:0] IVP_SLOT_WORDS     = 14'h0004;

    // ========================================================================
    // Clock output divider and reset values.
    localparam logic [7:0]  IVP_CLOCK_OUTPUT_PIN_DIV_RST = 8'h00;
    localparam logic [7:0]  IVP_MASK_RST       = 8'h00;

    // Sequencer handshake states.
    typedef enum logic [2:0] {
        IVP_ST_RESET = 3'b001,
        IVP_ST_IDLE  = 3'b010,
        IVP_ST_WAIT  = 3'b100
    } ivp_state_t;

endpackage : ivp_pkg

// ---- rtl/ivp_sync.sv ----
`timescale 1ns/1ns
// ============================================================================
// Three-stage input synchroniser; a change counts when stages two and three agree.
module ivp_sync
    import ivp_pkg::*;
#(
    parameter int W = 8
)
(
    input  wire logic         clk,   // Processor clock.
    input  wire logic         nrst,  // Asynchronous reset, active low.
    input  wire logic [W-1:0] d_in,  // Asynchronous inputs.
    output logic      [W-1:0] q_out  // Filtered synchronous level.
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } ivp_sync_st_t;

    ivp_sync_st_t st_reg;
    ivp_sync_st_t st_next;

    // Shift the stages and update the level only when two and three agree.
    always_comb
    begin
        st_next    = st_reg;
        st_next.s1 = d_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < W; i++)
        begin
            if (st_reg.s2[i] == st_reg.s3[i])
            begin
                st_next.q[i] = st_reg.s3[i];
            end
        end
    end

    // Register the whole state.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign q_out = st_reg.q;

endmodule : ivp_sync

// ---- rtl/ivp_selector.sv ----
`timescale 1ns/1ns
module ivp_selector
    import ivp_pkg::*;
#(
    parameter logic [1:0] VARIANT    = IVP_VAR_TWO_PORT,
    parameter logic [7:0] CLOCK_OUTPUT_PIN_DIV = 8'h00
)
(
    input  wire logic                  clk,                // Processor clock.
    input  wire logic                  nrst,               // Device reset, active low.
    input  wire logic                  ext_irq_dedicated,  // Dedicated pin request, active high level.
    input  wire logic                  ext_irq_shared_tx,  // Shared pin one request.
    input  wire logic                  ext_irq_shared_rx,  // Shared pin zero request.
    input  wire logic                  pins_as_irq,        // Port one pins serve as interrupt inputs.
    input  wire logic                  sp0_tx_req,         // Port zero transmit request.
    input  wire logic                  sp0_rx_req,         // Port zero receive request.
    input  wire logic                  sp1_tx_req,         // Port one transmit request.
    input  wire logic                  sp1_rx_req,         // Port one receive request.
    input  wire logic                  host_wr_req,        // Mailbox written by host.
    input  wire logic                  host_rd_req,        // Mailbox read by host.
    input  wire logic                  timer_req,          // Timer request.
    input  wire logic [7:0]            interrupt_mask_reg, // Per-source enables, priority order.
    input  wire logic                  vec_ack,            // Sequencer took the vector.
    output logic                       vec_valid,          // Vector presented.
    output logic      [IVP_ADDR_W-1:0] vec_addr,           // Vector address.
    output logic                       vec_is_reset,       // Presented vector is reset entry.
    output logic      [2:0]            vec_src,            // Index of selected source.
    output logic                       sp1_enabled,        // Port one pins active as port.
    output logic                       clock_output_pin    // Clock output.
);

    // ========================================================================
    // State.
    typedef struct packed {
        ivp_state_t            state;
        logic                  valid;
        logic [IVP_ADDR_W-1:0] addr;
        logic                  is_reset;
        logic [2:0]            src;
        logic                  sp1_en;
        logic [7:0]            div;
        logic                  clk_out;
    } ivp_st_t;

    ivp_st_t    st_reg;
    ivp_st_t    st_next;
    logic [2:0] pin_sync;
    logic [7:0] req;
    logic [7:0] pend;
    logic       any;
    logic [2:0] win;

    // Vector address per source and variant.
    function automatic logic [IVP_ADDR_W-1:0] vec_of(input logic [1:0] v, input logic [2:0] s);
        logic [IVP_ADDR_W-1:0] a;
        a = IVP_VEC_RESET;
        case (s)
            3'h0: a = IVP_VEC_DEDICATED;
            3'h1: a = IVP_VEC_0008;
            3'h2: a = IVP_VEC_000C;
            3'h3: a = (v == IVP_VAR_HOST_PORT) ? IVP_VEC_0010 : IVP_VEC_0008;
            3'h4: a = (v == IVP_VAR_HOST_PORT) ? IVP_VEC_0014 : IVP_VEC_000C;
            3'h5: a = (v == IVP_VAR_HOST_PORT) ? IVP_VEC_0018 : IVP_VEC_0010;
            3'h6: a = (v == IVP_VAR_HOST_PORT) ? IVP_VEC_001C : IVP_VEC_0014;
            default: a = (v == IVP_VAR_HOST_PORT) ? IVP_VEC_0020 : IVP_VEC_0018;
        endcase
        return a;
    endfunction : vec_of

    // ========================================================================
    // Pin requests come from outside and are synchronised.
    ivp_sync #(.W(3)) u_pin_sync
    (
        .clk   (clk),
        .nrst  (nrst),
        .d_in  ({ext_irq_shared_rx, ext_irq_shared_tx, ext_irq_dedicated}),
        .q_out (pin_sync)
    );

    // Gather requests; sources absent in a variant stay quiet, shared slots follow the pin mode.
    always_comb
    begin
        req                    = '0;
        req[IVP_SRC_DEDICATED] = pin_sync[0];
        req[IVP_SRC_HOST_WR]   = (VARIANT == IVP_VAR_HOST_PORT) && host_wr_req;
        req[IVP_SRC_HOST_RD]   = (VARIANT == IVP_VAR_HOST_PORT) && host_rd_req;
        req[IVP_SRC_SP0_TX]    = (VARIANT != IVP_VAR_ONE_PORT) && sp0_tx_req;
        req[IVP_SRC_SP0_RX]    = (VARIANT != IVP_VAR_ONE_PORT) && sp0_rx_req;
        req[IVP_SRC_SHARED_TX] = pins_as_irq ? pin_sync[1] : sp1_tx_req;
        req[IVP_SRC_SHARED_RX] = pins_as_irq ? pin_sync[2] : sp1_rx_req;
        req[IVP_SRC_TIMER]     = timer_req;
    end

    // Mask every source, then pick the lowest index, which is highest priority.
    assign pend = req & interrupt_mask_reg;
    assign any  = |pend;
    always_comb
    begin
        win = 3'h0;
        for (int i = IVP_NUM_SRC - 1; i >= 0; i--)
        begin
            if (pend[i])
            begin
                win = 3'(i);
            end
        end
    end

    // Next state: reset entry first, then hold a vector until acknowledged.
    always_comb
    begin
        st_next        = st_reg;
        st_next.sp1_en = !pins_as_irq;
        // Free-running clock output divider; a warm reset stops it and reloads its reset value.
        if (st_reg.div == CLOCK_OUTPUT_PIN_DIV)
        begin
            st_next.div     = IVP_CLOCK_OUTPUT_PIN_DIV_RST;
            st_next.clk_out = !st_reg.clk_out;
        end
        else
        begin
            st_next.div = st_reg.div + 8'h01;
        end
        case (st_reg.state)
            IVP_ST_RESET:
            begin
                st_next.valid    = 1'b1;
                st_next.is_reset = 1'b1;
                st_next.addr     = IVP_VEC_RESET;
                st_next.state    = IVP_ST_WAIT;
            end
            IVP_ST_IDLE:
            begin
                if (any)
                begin
                    st_next.valid    = 1'b1;
                    st_next.is_reset = 1'b0;
                    st_next.src      = win;
                    st_next.addr     = vec_of(VARIANT, win);
                    st_next.state    = IVP_ST_WAIT;
                end
            end
            IVP_ST_WAIT:
            begin
                if (vec_ack)
                begin
                    st_next.valid    = 1'b0;
                    st_next.is_reset = 1'b0;
                    st_next.state    = IVP_ST_IDLE;
                end
            end
            default:
            begin
                st_next.state = IVP_ST_RESET;
            end
        endcase
    end

    // Register the whole state; reset loads IVP_ST_RESET and sets sp1_en, and clears the rest.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_reg <= '{state: IVP_ST_RESET, valid: 1'b0, addr: IVP_VEC_RESET, is_reset: 1'b0,
                        src: 3'h0, sp1_en: 1'b1, div: IVP_CLOCK_OUTPUT_PIN_DIV_RST, clk_out: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs come straight from the state register.
    assign vec_valid        = st_reg.valid;
    assign vec_addr         = st_reg.addr;
    assign vec_is_reset     = st_reg.is_reset;
    assign vec_src          = st_reg.src;
    assign sp1_enabled      = st_reg.sp1_en;
    assign clock_output_pin = st_reg.clk_out;

    // ========================================================================
    // Checks.
    sequence s_reset_release;
        $rose(nrst);
    endsequence

    AST_RESET_VECTOR: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.state == IVP_ST_RESET |=> vec_valid && vec_is_reset && vec_addr == IVP_VEC_RESET)
        else $error("Reset entry vector is not address zero.");

    AST_RESET_FIRST: assert property (@(posedge clk) s_reset_release |-> ##1 vec_is_reset)
        else $error("Reset entry not presented after reset release.");

    AST_MASKED_SILENT: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.state == IVP_ST_IDLE && pend == 8'h00 |=> !vec_valid)
        else $error("Vector raised with no unmasked request.");

    AST_PICK_HIGHEST: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.state == IVP_ST_IDLE && any |=> vec_valid && (($past(pend) >> vec_src) & 8'h01) == 8'h01
        && (($past(pend) & ((8'h01 << vec_src) - 8'h01)) == 8'h00))
        else $error("Selected source is not the highest unmasked one.");

    AST_DEDICATED_TOP: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.state == IVP_ST_IDLE && pend[IVP_SRC_DEDICATED] |=> vec_addr == IVP_VEC_DEDICATED)
        else $error("Dedicated pin did not win.");

    AST_SLOT_ALIGN: assert property (@(posedge clk) disable iff (!nrst)
        vec_valid |-> (vec_addr & (IVP_SLOT_WORDS - 14'h0001)) == 14'h0000)
        else $error("Vector not on a four-word slot.");

    AST_TIMER_VEC: assert property (@(posedge clk) disable iff (!nrst)
        vec_valid && !vec_is_reset && vec_src == 3'h7 |->
        vec_addr == ((VARIANT == IVP_VAR_HOST_PORT) ? IVP_VEC_0020 : IVP_VEC_0018))
        else $error("Timer vector wrong for variant.");

    AST_HOLD_UNTIL_ACK: assert property (@(posedge clk) disable iff (!nrst)
        vec_valid && !vec_ack |=> vec_valid && $stable(vec_addr))
        else $error("Vector dropped before acknowledge.");

    AST_CLOCK_TOGGLES: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.div == CLOCK_OUTPUT_PIN_DIV |=> clock_output_pin != $past(clock_output_pin))
        else $error("Clock output failed to toggle.");

endmodule : ivp_selector

// ---- test/ivp_seq_model.sv ----
`timescale 1ns/1ns
// ============================================================================
// Sequencer model: takes each presented vector after a set number of cycles.
module ivp_seq_model
    import ivp_pkg::*;
(
    input  wire logic                  clk,        // Processor clock.
    input  wire logic                  nrst,       // Reset, active low.
    input  wire logic                  vec_valid,  // Vector presented.
    input  wire logic [IVP_ADDR_W-1:0] vec_addr,   // Vector address.
    input  wire logic [2:0]            vec_src,    // Selected source.
    input  wire logic [3:0]            ack_delay,  // Cycles to wait before taking.
    output logic                       vec_ack,    // Vector taken.
    output logic      [IVP_ADDR_W-1:0] taken_addr, // Last address taken.
    output logic      [2:0]            taken_src,  // Last source taken.
    output int                         taken_cnt   // Vectors taken so far.
);
    logic [3:0] wait_cnt;
    logic       armed;

    initial taken_cnt = 0;

    // Acknowledge changes off the sampling edge and lasts one cycle; re-arms only once the vector drops.
    always @(negedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            vec_ack  <= 1'b0;
            wait_cnt <= 4'h0;
            armed    <= 1'b1;
        end
        else if (vec_ack)
        begin
            // The vector has already dropped here, so arm at once for the next one.
            vec_ack  <= 1'b0;
            wait_cnt <= 4'h0;
            armed    <= !vec_valid;
        end
        else if (!vec_valid)
            armed <= 1'b1;
        else if (armed && wait_cnt >= ack_delay)
            vec_ack <= 1'b1;
        else if (armed)
            wait_cnt <= wait_cnt + 4'h1;
    end

    // Captures what the vector carried at the edge where the acknowledge is sampled.
    always @(posedge clk)
    begin
        if (nrst && vec_ack && vec_valid)
        begin
            taken_addr <= vec_addr;
            taken_src  <= vec_src;
            taken_cnt  <= taken_cnt + 1;
        end
    end
endmodule : ivp_seq_model

// ---- test/ivp_tb.sv ----
`timescale 1ns/1ns
// ============================================================================
// Bench: three variants side by side, each with its own sequencer model.
module tb
    import ivp_pkg::*;
;
    logic                  clk, nrst, pins_as_irq, ext_irq_dedicated, ext_irq_shared_tx, ext_irq_shared_rx;
    logic                  sp0_tx_req, sp0_rx_req, sp1_tx_req, sp1_rx_req, host_wr_req, host_rd_req, timer_req;
    logic [7:0]            mask [3];
    logic [3:0]            ack_delay [3];
    wire  [2:0]            vec_valid, vec_is_reset, sp1_enabled, clock_output_pin;
    wire  [IVP_ADDR_W-1:0] vec_addr [3];
    wire  [IVP_ADDR_W-1:0] taken_addr [3];
    wire  [2:0]            taken_src [3];
    wire  [31:0]           taken_cnt [3];
    int                    fails, tests_run;

    // ========================================================================
    // Instances, one per variant; divider setting follows the variant index.
    for (genvar v = 0; v < 3; v++)
    begin : g_var
        wire       vec_ack;
        wire [2:0] vec_src;
        ivp_selector #(.VARIANT(2'(v)), .CLOCK_OUTPUT_PIN_DIV(8'(v))) ivp_selector_inst (.clk(clk), .nrst(nrst),
            .ext_irq_dedicated(ext_irq_dedicated), .ext_irq_shared_tx(ext_irq_shared_tx),
            .ext_irq_shared_rx(ext_irq_shared_rx), .pins_as_irq(pins_as_irq), .sp0_tx_req(sp0_tx_req),
            .sp0_rx_req(sp0_rx_req), .sp1_tx_req(sp1_tx_req), .sp1_rx_req(sp1_rx_req),
            .host_wr_req(host_wr_req), .host_rd_req(host_rd_req), .timer_req(timer_req),
            .interrupt_mask_reg(mask[v]), .vec_ack(vec_ack), .vec_valid(vec_valid[v]), .vec_addr(vec_addr[v]),
            .vec_is_reset(vec_is_reset[v]), .vec_src(vec_src), .sp1_enabled(sp1_enabled[v]),
            .clock_output_pin(clock_output_pin[v]));
        ivp_seq_model ivp_seq_model_inst (.clk(clk), .nrst(nrst), .vec_valid(vec_valid[v]),
            .vec_addr(vec_addr[v]), .vec_src(vec_src), .ack_delay(ack_delay[v]), .vec_ack(vec_ack),
            .taken_addr(taken_addr[v]), .taken_src(taken_src[v]), .taken_cnt(taken_cnt[v]));
    end

    // Free-running clock that never stops or changes rate.
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ========================================================================
    // Helpers.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Expected vector of source i in variant v; zero means the source is absent.
    function automatic logic [31:0] exp_vec(input int v, input int i);
        if (i == 0)
            return 32'h4;
        if (v == 2)
            return 4 * (i + 1);
        if (i < 3 || (v == 1 && i < 5))
            return 32'h0;
        return 4 * (i - 1);
    endfunction : exp_vec

    // Drives source levels; shared slots go to the pins or to port one as use_pins says.
    task automatic set_reqs(input logic [7:0] r, input logic pins, input logic use_pins);
        pins_as_irq       = pins;
        ext_irq_dedicated = r[0];
        host_wr_req       = r[1];
        host_rd_req       = r[2];
        sp0_tx_req        = r[3];
        sp0_rx_req        = r[4];
        ext_irq_shared_tx = r[5] & use_pins;
        ext_irq_shared_rx = r[6] & use_pins;
        sp1_tx_req        = r[5] & !use_pins;
        sp1_rx_req        = r[6] & !use_pins;
        timer_req         = r[7];
    endtask : set_reqs

    task automatic wait_taken(input int v);
        logic [31:0] n;
        n = taken_cnt[v];
        for (int k = 0; k < 30 && taken_cnt[v] == n; k++)
            @(posedge clk) #1;
        check(taken_cnt[v] - n, 1);
    endtask : wait_taken

    task automatic no_vec(input int v);
        logic [31:0] n;
        n = taken_cnt[v];
        repeat (20) @(negedge clk);
        check(taken_cnt[v] - n, 0);
    endtask : no_vec

    // ========================================================================
    // Scenarios.
    task automatic t_reset_entry;
        nrst = 1'b1;
        @(posedge clk) #1;
        for (int v = 0; v < 3; v++)
        begin
            check(vec_valid[v], 1'b1);
            check(vec_is_reset[v], 1'b1);
            check(vec_addr[v], 0);
        end
        repeat (4) @(negedge clk);
    endtask : t_reset_entry

    // All sources pend while masked, then are served one by one as each is masked off.
    task automatic t_priority(input logic pins);
        for (int v = 0; v < 3; v++)
        begin
            ack_delay[v] = 4'(v);
            set_reqs(8'hFF, pins, pins);
            repeat (6) @(negedge clk);
            mask[v] = 8'hFF;
            for (int i = 0; i < 8; i++)
            begin
                if (exp_vec(v, i) != 0)
                begin
                    wait_taken(v);
                    check(taken_addr[v], exp_vec(v, i));
                    check(taken_src[v], i);
                    @(negedge clk);
                    mask[v][i] = 1'b0;
                end
            end
            set_reqs(8'h00, pins, pins);
            no_vec(v);
            mask[v] = 8'h00;
        end
    endtask : t_priority

    task automatic t_refused;
        set_reqs(8'hFF, 1'b1, 1'b1);
        no_vec(2);
        check(vec_valid[2], 1'b0);
        set_reqs(8'h1E, 1'b1, 1'b1);
        repeat (6) @(negedge clk);
        mask[1] = 8'hFF;
        no_vec(1);
        mask = '{default: 8'hFF};
        set_reqs(8'h60, 1'b0, 1'b1);
        no_vec(0);
        check(sp1_enabled[0], 1'b1);
        set_reqs(8'h00, 1'b0, 1'b1);
        repeat (6) @(negedge clk);
        set_reqs(8'h60, 1'b1, 1'b0);
        no_vec(1);
        check(sp1_enabled[1], 1'b0);
        set_reqs(8'h00, 1'b1, 1'b1);
        mask = '{default: 8'h00};
    endtask : t_refused

    task automatic t_clock_out;
        logic [2:0] prev;
        int         edges [3];
        edges = '{default: 0};
        prev = clock_output_pin;
        repeat (12)
        begin
            @(negedge clk);
            for (int v = 0; v < 3; v++)
                edges[v] += int'(clock_output_pin[v] != prev[v]);
            prev = clock_output_pin;
        end
        for (int v = 0; v < 3; v++)
            check(edges[v], 12 / (v + 1));
    endtask : t_clock_out

    // A timer vector held by a slow sequencer is wiped by a reset in mid-run.
    task automatic t_warm_reset;
        // Let an edge pass so that no input is driven twice in one time step.
        @(negedge clk);
        ack_delay = '{default: 4'h8};
        mask = '{default: 8'hFF};
        set_reqs(8'h80, 1'b1, 1'b1);
        repeat (3) @(negedge clk);
        for (int v = 0; v < 3; v++)
            check(vec_addr[v], exp_vec(v, 7));
        nrst = 1'b0;
        set_reqs(8'h00, 1'b1, 1'b1);
        mask = '{default: 8'h00};
        ack_delay = '{default: 4'h0};
        #1;
        for (int v = 0; v < 3; v++)
        begin
            check(vec_valid[v], 1'b0);
            check(sp1_enabled[v], 1'b1);
        end
        repeat (2) @(negedge clk);
        t_reset_entry();
        t_clock_out();
    endtask : t_warm_reset

    task automatic results;
        $display("checks run %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    // ========================================================================
    // Main sequence.
    initial
    begin
        fails = 0;
        tests_run = 0;
        nrst = 1'b0;
        mask = '{default: 8'h00};
        ack_delay = '{default: 4'h0};
        set_reqs(8'h00, 1'b1, 1'b1);
        // The modelled clock needs no lock time, so a short power-up hold stands in for the long one.
        repeat (2) @(negedge clk);
        t_reset_entry();
        t_priority(1'b1);
        t_priority(1'b0);
        t_refused();
        t_warm_reset();
        results();
    end

    // Watchdog well beyond the expected run of about four hundred cycles.
    initial
    begin
        #200000;
        fails++;
        results();
    end
endmodule : tb
